/* verilog/lmir_pkg.sv */
// Shared constants for the literal, move, indirect and return executor.
// Assumes a 14-bit instruction word and an 8-bit data path.
package lmir_pkg;
   localparam int INSTR_W  = 14;
   localparam int DATA_W   = 8;
   localparam int PTR_W    = 16;
   localparam int PC_W     = 15;
   localparam int BANK_W   = 5;
   localparam int PAGE_W   = 7;
   localparam int FADDR_W  = 7;
   localparam int BANK_LIT_W = 4;
   localparam int OFFSET_W = 6;

   // Opcode match values and masks.
   localparam logic [13:0] MSK_FULL      = 14'h3fff;
   localparam logic [13:0] OPC_NOP       = 14'h0000;
   localparam logic [13:0] OPC_RESET     = 14'h0001;
   localparam logic [13:0] OPC_INTRET    = 14'h0009;
   localparam logic [13:0] OPC_OPTION    = 14'h0062;
   localparam logic [13:0] MSK_LOADBANK  = 14'h3fe0;
   localparam logic [13:0] OPC_LOADBANK  = 14'h0020;
   localparam logic [13:0] MSK_LOADPAGE  = 14'h3f80;
   localparam logic [13:0] OPC_LOADPAGE  = 14'h3180;
   localparam logic [13:0] MSK_LOADACC   = 14'h3f00;
   localparam logic [13:0] OPC_LOADACC   = 14'h3000;
   localparam logic [13:0] MSK_STOREFILE = 14'h3f80;
   localparam logic [13:0] OPC_STOREFILE = 14'h0080;
   localparam logic [13:0] MSK_STOREIND  = 14'h3ff8;
   localparam logic [13:0] OPC_STOREIND  = 14'h0018;
   localparam logic [13:0] MSK_STOREOFF  = 14'h3f80;
   localparam logic [13:0] OPC_STOREOFF  = 14'h3f80;

   // Field positions inside the instruction word.
   localparam int IND_SEL_BIT = 2;
   localparam int OFF_SEL_BIT = 6;

   localparam logic [1:0] MODE_PREINC  = 2'h0;
   localparam logic [1:0] MODE_PREDEC  = 2'h1;
   localparam logic [1:0] MODE_POSTINC = 2'h2;
   localparam logic [1:0] MODE_POSTDEC = 2'h3;

   localparam logic [6:0] INDPORT0_ADDR = 7'h00;
   localparam logic [6:0] INDPORT1_ADDR = 7'h01;

   localparam logic [7:0]  ACCUM_RST  = 8'h00;
   localparam logic [7:0]  OPTION_RST = 8'hff;
   localparam logic [15:0] PTR_RST    = 16'h0000;
   localparam logic [14:0] PC_RST     = 15'h0000;
   localparam logic [4:0]  BANK_RST   = 5'h00;
   localparam logic [6:0]  PAGE_RST   = 7'h00;
   localparam logic        INT_EN_RST = 1'b0;
   localparam logic        CAUSE_RST  = 1'b1;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_FLUSH = 2'b10
   } exec_state_t;

   function automatic logic op_match(input logic [13:0] word,
                                     input logic [13:0] mask,
                                     input logic [13:0] code);
      return (word & mask) == code;
   endfunction
endpackage

/* verilog/indirect_pointer_unit.sv */
// Effective address and pointer update for the indirect store.
// Assumes the caller selects which pointer is fed in and stores the result.
`timescale 1ns/100ps
module indirect_pointer_unit
   import lmir_pkg::*;
#(
   parameter int PW = PTR_W
) (
   input  wire logic [PW-1:0]       ptr_in,
   input  wire logic [1:0]          mode,
   input  wire logic                use_offset,
   input  wire logic [OFFSET_W-1:0] offset,
   output logic      [PW-1:0]       eff_addr,
   output logic      [PW-1:0]       ptr_next
);
   logic [PW-1:0] inc_val;
   logic [PW-1:0] dec_val;
   logic [PW-1:0] off_val;

   // Plain modular arithmetic gives the wraparound at both ends.
   always_comb begin
      inc_val = PW'(ptr_in + PW'(1));
      dec_val = PW'(ptr_in - PW'(1));
      off_val = PW'(ptr_in + {{(PW-OFFSET_W){offset[OFFSET_W-1]}}, offset});
   end

   always_comb begin
      eff_addr = ptr_in;
      ptr_next = ptr_in;
      if (use_offset) begin
         eff_addr = off_val;
      end else begin
         case (mode)
            MODE_PREINC: begin
               eff_addr = inc_val;
               ptr_next = inc_val;
            end
            MODE_PREDEC: begin
               eff_addr = dec_val;
               ptr_next = dec_val;
            end
            MODE_POSTINC: begin
               ptr_next = inc_val;
            end
            MODE_POSTDEC: begin
               ptr_next = dec_val;
            end
            default: begin
               ptr_next = ptr_in;
            end
         endcase
      end
   end
endmodule

/* verilog/lmir_exec.sv */
// Executor for literal loads, moves, indirect stores, reset and interrupt return.
// Assumes instructions arrive on mclk from fetch logic and top_of_stack is the stack top.
//
// What this block does
// - Bank literal load writes a four-bit literal into the bank select register.
// - Page literal load writes seven-bit literal into high latch, flags untouched.
// - Accumulator literal load puts eight-bit literal into W, flags untouched.
// - Store to file copies W to the seven-bit addressed file register.
// - Indirect store mode field selects pre/post increment or decrement.
// - Pointer ends plus one, minus one, or unchanged for signed offset form.
// - Accesses to the indirect port go to the pointer's addressed location.
// - Sixteen-bit pointers wrap around at both ends.
// - Pointer updates and indirect stores never touch status flags.
// - Option load copies W into the option register in one cycle.
// - Software reset acts as hardware reset and clears reset-instruction cause flag.
// - Interrupt return pops stack, loads top into PC, takes two cycles.
// - Interrupt return sets the global interrupt enable bit.
`timescale 1ns/100ps
module lmir_exec
   import lmir_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   input  wire logic [INSTR_W-1:0] instr_word,
   input  wire logic               instr_valid,
   input  wire logic [PC_W-1:0]    top_of_stack,
   input  wire logic               int_enable_clear,
   output logic      [DATA_W-1:0]  accum_ff,
   output logic      [BANK_W-1:0]  bank_select_reg_ff,
   output logic      [PAGE_W-1:0]  program_counter_high_latch_ff,
   output logic      [DATA_W-1:0]  option_reg_ff,
   output logic      [PTR_W-1:0]   indirect_pointer0_ff,
   output logic      [PTR_W-1:0]   indirect_pointer1_ff,
   output logic      [PC_W-1:0]    pc_ff,
   output logic                    stack_pop_ff,
   output logic                    busy_ff,
   output logic                    file_wr_en_ff,
   output logic      [PTR_W-1:0]   file_wr_addr_ff,
   output logic      [DATA_W-1:0]  file_wr_data_ff,
   output logic                    global_interrupt_enable_ff,
   output logic                    soft_reset_ff,
   output logic                    reset_instruction_cause_flag_ff
);
   exec_state_t state_ff;
   logic        blk_rst;
   logic        exec;
   logic        dec_nop;
   logic        dec_reset;
   logic        dec_intret;
   logic        dec_option;
   logic        dec_bank;
   logic        dec_page;
   logic        dec_acc;
   logic        dec_file;
   logic        dec_ind;
   logic        dec_off;
   logic        ptr_sel;
   logic [PTR_W-1:0]   ptr_cur;
   logic [PTR_W-1:0]   eff_addr;
   logic [PTR_W-1:0]   ptr_next;
   logic [FADDR_W-1:0] faddr;

   // The one-cycle soft reset pulse resets everything a hardware reset would,
   // except its own cause flag, which must survive to be read.
   assign blk_rst = sys_rst | soft_reset_ff;
   assign exec    = instr_valid & (state_ff == ST_RUN) & ~soft_reset_ff;

   always_comb begin
      dec_nop    = op_match(instr_word, MSK_FULL, OPC_NOP);
      dec_reset  = op_match(instr_word, MSK_FULL, OPC_RESET);
      dec_intret = op_match(instr_word, MSK_FULL, OPC_INTRET);
      dec_option = op_match(instr_word, MSK_FULL, OPC_OPTION);
      dec_bank   = op_match(instr_word, MSK_LOADBANK, OPC_LOADBANK);
      dec_page   = op_match(instr_word, MSK_LOADPAGE, OPC_LOADPAGE);
      dec_acc    = op_match(instr_word, MSK_LOADACC, OPC_LOADACC);
      dec_file   = op_match(instr_word, MSK_STOREFILE, OPC_STOREFILE);
      dec_ind    = op_match(instr_word, MSK_STOREIND, OPC_STOREIND);
      dec_off    = op_match(instr_word, MSK_STOREOFF, OPC_STOREOFF);
      faddr      = instr_word[FADDR_W-1:0];
      ptr_sel    = dec_off ? instr_word[OFF_SEL_BIT] : instr_word[IND_SEL_BIT];
      ptr_cur    = ptr_sel ? indirect_pointer1_ff : indirect_pointer0_ff;
   end

   indirect_pointer_unit #(
      .PW(PTR_W)
   ) u_ptr (
      .ptr_in     (ptr_cur),
      .mode       (instr_word[1:0]),
      .use_offset (dec_off),
      .offset     (instr_word[OFFSET_W-1:0]),
      .eff_addr   (eff_addr),
      .ptr_next   (ptr_next)
   );

   // The word fetched behind an interrupt return is stale and is dropped.
   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         state_ff <= ST_RUN;
         busy_ff  <= 1'b0;
      end else begin
         case (state_ff)
            ST_RUN: begin
               if (exec && dec_intret) begin
                  state_ff <= ST_FLUSH;
                  busy_ff  <= 1'b1;
               end
            end
            ST_FLUSH: begin
               state_ff <= ST_RUN;
               busy_ff  <= 1'b0;
            end
            default: begin
               state_ff <= ST_RUN;
               busy_ff  <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         pc_ff        <= PC_RST;
         stack_pop_ff <= 1'b0;
      end else begin
         stack_pop_ff <= exec & dec_intret;
         if (exec && dec_intret) begin
            pc_ff <= top_of_stack;
         end else if (exec) begin
            pc_ff <= PC_W'(pc_ff + PC_W'(1));
         end
      end
   end

   // No path here touches a status flag; this block drives none.
   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         accum_ff <= ACCUM_RST;
      end else if (exec && dec_acc) begin
         accum_ff <= instr_word[DATA_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         bank_select_reg_ff <= BANK_RST;
      end else if (exec && dec_bank) begin
         // Upper bank bit is loaded as zero.
         bank_select_reg_ff <= BANK_W'(instr_word[BANK_LIT_W-1:0]);
      end
   end

   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         program_counter_high_latch_ff <= PAGE_RST;
      end else if (exec && dec_page) begin
         program_counter_high_latch_ff <= instr_word[PAGE_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         option_reg_ff <= OPTION_RST;
      end else if (exec && dec_option) begin
         option_reg_ff <= accum_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         indirect_pointer0_ff <= PTR_RST;
         indirect_pointer1_ff <= PTR_RST;
      end else if (exec && (dec_ind || dec_off)) begin
         if (ptr_sel) begin
            indirect_pointer1_ff <= ptr_next;
         end else begin
            indirect_pointer0_ff <= ptr_next;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         file_wr_en_ff   <= 1'b0;
         file_wr_addr_ff <= PTR_RST;
         file_wr_data_ff <= ACCUM_RST;
      end else begin
         file_wr_en_ff <= exec & (dec_file | dec_ind | dec_off);
         if (exec && dec_file) begin
            file_wr_data_ff <= accum_ff;
            if (faddr == INDPORT0_ADDR) begin
               file_wr_addr_ff <= indirect_pointer0_ff;
            end else if (faddr == INDPORT1_ADDR) begin
               file_wr_addr_ff <= indirect_pointer1_ff;
            end else begin
               file_wr_addr_ff <= PTR_W'({bank_select_reg_ff, faddr});
            end
         end else if (exec && (dec_ind || dec_off)) begin
            file_wr_data_ff <= accum_ff;
            file_wr_addr_ff <= eff_addr;
         end
      end
   end

   // An interrupt return that meets a clear in the same cycle leaves the
   // enable set, so the return is never lost.
   always_ff @(posedge mclk) begin
      if (blk_rst) begin
         global_interrupt_enable_ff <= INT_EN_RST;
      end else if (exec && dec_intret) begin
         global_interrupt_enable_ff <= 1'b1;
      end else if (int_enable_clear) begin
         global_interrupt_enable_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         soft_reset_ff <= 1'b0;
      end else begin
         soft_reset_ff <= exec & dec_reset;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reset_instruction_cause_flag_ff <= CAUSE_RST;
      end else if (exec && dec_reset) begin
         reset_instruction_cause_flag_ff <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   bank_load_a: assert property (exec && dec_bank |=>
      bank_select_reg_ff == BANK_W'($past(instr_word[BANK_LIT_W-1:0])))
      else $error("bank select not loaded from literal");
   page_load_a: assert property (exec && dec_page |=>
      program_counter_high_latch_ff == $past(instr_word[PAGE_W-1:0]))
      else $error("high latch not loaded from literal");
   accum_load_a: assert property (exec && dec_acc |=>
      accum_ff == $past(instr_word[DATA_W-1:0]) && !file_wr_en_ff)
      else $error("accumulator not loaded from literal");
   file_store_a: assert property (exec && dec_file && faddr > INDPORT1_ADDR |=>
      file_wr_en_ff && file_wr_data_ff == $past(accum_ff)
      && file_wr_addr_ff == PTR_W'({$past(bank_select_reg_ff), $past(faddr)}))
      else $error("file store wrong");
   postinc_mode_a: assert property (exec && dec_ind && !ptr_sel
      && instr_word[1:0] == MODE_POSTINC |=>
      file_wr_addr_ff == $past(indirect_pointer0_ff)
      && indirect_pointer0_ff == PTR_W'($past(indirect_pointer0_ff) + PTR_W'(1)))
      else $error("post increment store wrong");
   offset_keep_a: assert property (exec && dec_off && ptr_sel |=>
      $stable(indirect_pointer1_ff) && file_wr_en_ff)
      else $error("offset form moved the pointer");
   port_redirect_a: assert property (exec && dec_file && faddr == INDPORT1_ADDR |=>
      file_wr_addr_ff == $past(indirect_pointer1_ff))
      else $error("indirect port not redirected");
   ptr_wrap_a: assert property (exec && dec_ind && !ptr_sel
      && instr_word[1:0] == MODE_PREINC && indirect_pointer0_ff == '1 |=>
      indirect_pointer0_ff == '0 && file_wr_addr_ff == '0)
      else $error("pointer did not wrap");
   option_load_a: assert property (exec && dec_option |=>
      option_reg_ff == $past(accum_ff))
      else $error("option register not loaded");
   soft_reset_a: assert property (exec && dec_reset |=>
      soft_reset_ff && !reset_instruction_cause_flag_ff ##1
      !soft_reset_ff && accum_ff == ACCUM_RST && pc_ff == PC_RST)
      else $error("software reset sequence wrong");
   int_return_a: assert property (exec && dec_intret |=>
      stack_pop_ff && busy_ff && pc_ff == $past(top_of_stack) ##1
      !stack_pop_ff && !busy_ff && pc_ff == $past(pc_ff))
      else $error("interrupt return not two cycles");
   int_enable_set_a: assert property (exec && dec_intret |=>
      global_interrupt_enable_ff)
      else $error("interrupt enable not set");
   nop_only_pc_a: assert property (exec && dec_nop |=>
      pc_ff == PC_W'($past(pc_ff) + PC_W'(1)) && !file_wr_en_ff && $stable(accum_ff))
      else $error("no-operation changed state");
   predec_mode_a: assert property (exec && dec_ind && ptr_sel
      && instr_word[1:0] == MODE_PREDEC |=>
      file_wr_addr_ff == indirect_pointer1_ff
      && indirect_pointer1_ff == PTR_W'($past(indirect_pointer1_ff) - PTR_W'(1)))
      else $error("pre decrement store wrong");

   // A word offered while a return flushes or a soft reset is in flight must
   // leave no trace; the fetch side is free to keep offering it.
   flush_drop_a: assert property (state_ff == ST_FLUSH |=>
      $stable(accum_ff) && $stable(pc_ff) && !file_wr_en_ff && !stack_pop_ff)
      else $error("word behind interrupt return not dropped");
   reset_drop_a: assert property (soft_reset_ff |=>
      !file_wr_en_ff && !stack_pop_ff && accum_ff == ACCUM_RST)
      else $error("word during software reset not dropped");
   enable_wins_a: assert property (exec && dec_intret && int_enable_clear |=>
      global_interrupt_enable_ff)
      else $error("interrupt return lost to a clear");
   enable_clear_a: assert property (int_enable_clear && !(exec && dec_intret) |=>
      !global_interrupt_enable_ff)
      else $error("interrupt enable not cleared");

   int_return_c: cover property (exec && dec_intret ##2 exec);
   ind_store_c: cover property (exec && dec_ind ##1 exec && dec_off);
   soft_reset_c: cover property (exec && dec_reset ##2 exec);
   wrap_c: cover property (exec && dec_ind && indirect_pointer0_ff == '1);
   enable_race_c: cover property (exec && dec_intret && int_enable_clear);
endmodule

/* tb/fetch_model.sv */
// Program memory side of the executor: forwards one posted instruction word a cycle
// and keeps a small return stack whose top answers the interrupt return.
// Assumes the bench posts words just after a rising edge of mclk.
`timescale 1ns/100ps
module fetch_model
   import lmir_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   input  wire logic [INSTR_W-1:0] post_word,
   input  wire logic               post_valid,
   input  wire logic               stack_pop_ff,
   output logic      [INSTR_W-1:0] instr_word,
   output logic                    instr_valid,
   output logic      [PC_W-1:0]    top_of_stack
);
   logic [1:0]         sp_ff;
   logic [INSTR_W-1:0] last_ff;

   // An idle bus shows the inverse of the last word, so a stale word never looks valid.
   assign instr_word  = post_valid ? post_word : ~last_ff;
   assign instr_valid = post_valid;
   // Each stack level holds a distinct return address, so a missed pop is visible.
   assign top_of_stack = 15'h1a5c ^ {13'h0000, sp_ff};

   always_ff @(posedge mclk) begin
      last_ff <= instr_word;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sp_ff <= 2'h3;
      end else if (stack_pop_ff) begin
         sp_ff <= sp_ff - 2'h1;
      end
   end
endmodule

/* tb/literal_move_indirect_return_exec_tb.sv */
// Self-checking bench for the literal, move, indirect and return executor.
// Assumes lmir_exec and the fetch model; inputs change 1 ns after each rising edge.
`timescale 1ns/100ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module literal_move_indirect_return_exec_tb
   import lmir_pkg::*;
;
   logic mclk, sys_rst, post_valid, instr_valid, int_enable_clear, stack_pop_ff, busy_ff;
   logic file_wr_en_ff, soft_reset_ff, global_interrupt_enable_ff;
   logic reset_instruction_cause_flag_ff;
   logic [INSTR_W-1:0] post_word, instr_word;
   logic [PC_W-1:0]    top_of_stack, pc_ff;
   logic [DATA_W-1:0]  accum_ff, option_reg_ff, file_wr_data_ff;
   logic [BANK_W-1:0]  bank_select_reg_ff;
   logic [PAGE_W-1:0]  program_counter_high_latch_ff;
   logic [PTR_W-1:0]   indirect_pointer0_ff, indirect_pointer1_ff, file_wr_addr_ff;
   int                 failures, tests_run;

   fetch_model u_fetch (.mclk(mclk), .sys_rst(sys_rst), .post_word(post_word),
      .post_valid(post_valid), .stack_pop_ff(stack_pop_ff), .instr_word(instr_word),
      .instr_valid(instr_valid), .top_of_stack(top_of_stack));

   lmir_exec u_dut (.mclk(mclk), .sys_rst(sys_rst), .instr_word(instr_word),
      .instr_valid(instr_valid), .top_of_stack(top_of_stack),
      .int_enable_clear(int_enable_clear),
      .accum_ff(accum_ff), .bank_select_reg_ff(bank_select_reg_ff),
      .program_counter_high_latch_ff(program_counter_high_latch_ff),
      .option_reg_ff(option_reg_ff), .indirect_pointer0_ff(indirect_pointer0_ff),
      .indirect_pointer1_ff(indirect_pointer1_ff), .pc_ff(pc_ff),
      .stack_pop_ff(stack_pop_ff), .busy_ff(busy_ff), .file_wr_en_ff(file_wr_en_ff),
      .file_wr_addr_ff(file_wr_addr_ff), .file_wr_data_ff(file_wr_data_ff),
      .global_interrupt_enable_ff(global_interrupt_enable_ff),
      .soft_reset_ff(soft_reset_ff),
      .reset_instruction_cause_flag_ff(reset_instruction_cause_flag_ff));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic complete_run();
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Holds the word valid across one edge; valid stays up so words can follow back to back.
   task automatic step(input logic [INSTR_W-1:0] w);
      post_word  = w;
      post_valid = 1'b1;
      @(posedge mclk);
      #1;
   endtask

   task automatic idle();
      post_valid = 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic t_reset_values();
      `CHECK(accum_ff, 8'h00)
      `CHECK(option_reg_ff, 8'hff)
      `CHECK(indirect_pointer1_ff, 16'h0000)
      `CHECK(reset_instruction_cause_flag_ff, 1'b1)
   endtask

   task automatic t_literals();
      step(14'h003f);
      `CHECK(bank_select_reg_ff, 5'h0f)
      step(14'h0020);
      `CHECK(bank_select_reg_ff, 5'h00)
      step(14'h31ff);
      `CHECK(program_counter_high_latch_ff, 7'h7f)
      step(14'h30a5);
      `CHECK(accum_ff, 8'ha5)
      idle();
   endtask

   task automatic t_nop();
      logic [PC_W-1:0] pc_before;
      pc_before = pc_ff;
      step(14'h0000);
      idle();
      `CHECK(pc_ff, pc_before + 15'h0001)
      `CHECK(accum_ff, 8'ha5)
      `CHECK(file_wr_en_ff, 1'b0)
   endtask

   task automatic t_store_file();
      step(14'h304f);
      step(14'h0022);
      step(14'h0085);
      `CHECK(file_wr_en_ff, 1'b1)
      `CHECK(file_wr_addr_ff, 16'h0105)
      `CHECK(file_wr_data_ff, 8'h4f)
      idle();
      `CHECK(file_wr_en_ff, 1'b0)
   endtask

   // Walks the pointer round zero both ways, so wrap and pre/post ordering are exercised.
   task automatic t_indirect();
      logic [1:0]       mode_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      logic [PTR_W-1:0] addr_tab [4] = '{16'h0001, 16'h0000, 16'h0000, 16'hffff};
      logic [PTR_W-1:0] ptr_tab  [4] = '{16'h0001, 16'h0000, 16'hffff, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         step(14'h001c | {12'h000, mode_tab[i]});
         `CHECK(file_wr_en_ff, 1'b1)
         `CHECK(file_wr_addr_ff, addr_tab[i])
         `CHECK(indirect_pointer1_ff, ptr_tab[i])
         `CHECK(file_wr_data_ff, 8'h4f)
      end
      `CHECK(indirect_pointer0_ff, 16'h0000)
      step(14'h0019);
      `CHECK(file_wr_addr_ff, 16'hffff)
      `CHECK(indirect_pointer0_ff, 16'hffff)
      step(14'h0018);
      `CHECK(file_wr_addr_ff, 16'h0000)
      `CHECK(indirect_pointer0_ff, 16'h0000)
      step(14'h001a);
      `CHECK(file_wr_addr_ff, 16'h0000)
      `CHECK(indirect_pointer0_ff, 16'h0001)
      `CHECK(indirect_pointer1_ff, 16'h0000)
      step(14'h3fe0);
      `CHECK(file_wr_addr_ff, 16'hffe0)
      `CHECK(indirect_pointer1_ff, 16'h0000)
      step(14'h3fdf);
      `CHECK(file_wr_addr_ff, 16'h001f)
      idle();
   endtask

   task automatic t_port_option();
      step(14'h30c3);
      step(14'h0081);
      `CHECK(file_wr_addr_ff, 16'h0000)
      `CHECK(file_wr_data_ff, 8'hc3)
      step(14'h0062);
      `CHECK(option_reg_ff, 8'hc3)
      idle();
   endtask

   task automatic t_int_return();
      int_enable_clear = 1'b1;
      idle();
      int_enable_clear = 1'b0;
      `CHECK(global_interrupt_enable_ff, 1'b0)
      step(14'h0009);
      `CHECK(stack_pop_ff, 1'b1)
      `CHECK(busy_ff, 1'b1)
      `CHECK(pc_ff, 15'h1a5f)
      `CHECK(global_interrupt_enable_ff, 1'b1)
      step(14'h3077);
      `CHECK(busy_ff, 1'b0)
      `CHECK(stack_pop_ff, 1'b0)
      `CHECK(accum_ff, 8'hc3)
      int_enable_clear = 1'b1;
      idle();
      `CHECK(global_interrupt_enable_ff, 1'b0)
      // The clear is still up when the return executes; the return must win.
      step(14'h0009);
      int_enable_clear = 1'b0;
      `CHECK(pc_ff, 15'h1a5e)
      `CHECK(global_interrupt_enable_ff, 1'b1)
      idle();
   endtask

   task automatic t_soft_reset();
      step(14'h001c);
      step(14'h0001);
      `CHECK(soft_reset_ff, 1'b1)
      `CHECK(reset_instruction_cause_flag_ff, 1'b0)
      step(14'h30ff);
      `CHECK(soft_reset_ff, 1'b0)
      `CHECK(accum_ff, 8'h00)
      `CHECK(option_reg_ff, 8'hff)
      `CHECK(indirect_pointer1_ff, 16'h0000)
      `CHECK(pc_ff, 15'h0000)
      `CHECK(global_interrupt_enable_ff, 1'b0)
      `CHECK(reset_instruction_cause_flag_ff, 1'b0)
      `CHECK(indirect_pointer0_ff, 16'h0000)
      `CHECK(bank_select_reg_ff, 5'h00)
      `CHECK(program_counter_high_latch_ff, 7'h00)
      step(14'h3011);
      `CHECK(accum_ff, 8'h11)
      idle();
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      complete_run();
   end

   initial begin
      failures   = 0;
      tests_run  = 0;
      sys_rst    = 1'b1;
      post_valid = 1'b0;
      post_word  = 14'h0000;
      int_enable_clear = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      t_reset_values();
      t_literals();
      t_nop();
      t_store_file();
      t_indirect();
      t_port_option();
      t_int_return();
      t_soft_reset();
      complete_run();
   end
endmodule
